// *** logic/fhm_regs.svh ***
// Purpose: register offsets, command value, limits and sizes of the fault history memory
// Assumes: parameter bus with 16-bit word addresses; 32-bit registers span two words
// Notes: included by the design modules and the bench
`ifndef FHM_REGS_SVH
`define FHM_REGS_SVH

`define FHM_OFS_PWR_ON_LO 16'h3b04
`define FHM_OFS_PWR_ON_HI 16'h3b06
`define FHM_OFS_CLEAR 16'h3b08
`define FHM_OFS_REWIND 16'h3b0a
`define FHM_OFS_CODE 16'h3c02
`define FHM_OFS_CLASS 16'h3c04
`define FHM_OFS_TIME_LO 16'h3c06
`define FHM_OFS_TIME_HI 16'h3c07
`define FHM_OFS_QUAL 16'h3c08
`define FHM_OFS_SPEED 16'h3c10
`define FHM_OFS_CURRENT 16'h3c12
`define FHM_OFS_TEMP 16'h3c16
`define FHM_CMD_ONE 16'h0001
`define FHM_CLASS_MAX 3'h4
`define FHM_TIME_MAX 32'h1fffffff
`define FHM_DEPTH 8
`define FHM_PTR_W 3
`define FHM_CNT_W 4

`endif

// *** logic/fhm_pkg.sv ***
// Purpose: types shared by the fault history memory
// Assumes: field widths are written here as literals, not taken from fhm_regs.svh
// Notes: none
package fhm_pkg;
  typedef struct packed {
    logic [15:0] code;
    logic [2:0] severity;
    logic [31:0] stamp;
    logic [15:0] extra;
    logic [15:0] speed;
    logic [15:0] current;
    logic [15:0] temp;
  } fhm_entry_t;

  typedef enum logic [1:0] {
    FHM_IDLE = 2'b01,
    FHM_ERASE = 2'b10
  } fhm_state_t;
endpackage

// *** logic/fhm_store.sv ***
// Purpose: entry array of the fault history memory
// Assumes: one write port and one asynchronous read port
// Notes: no reset on the array; validity is tracked by the owner
`timescale 1ns/1ns
`include "fhm_regs.svh"
module fhm_store (
  // clock
  input wire logic core_clk,
  // write side
  input wire logic wr_en,
  input wire logic [`FHM_PTR_W-1:0] wr_idx,
  input wire fhm_pkg::fhm_entry_t wr_entry,
  // read side
  input wire logic [`FHM_PTR_W-1:0] rd_idx,
  output fhm_pkg::fhm_entry_t rd_entry
);
  fhm_pkg::fhm_entry_t mem [`FHM_DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_entry;
    end
  end

  assign rd_entry = mem[rd_idx];
endmodule

// *** logic/fhm_top.sv ***
// Purpose: fault history memory with latched readout and power-on counter
// Assumes: single-cycle parameter bus, read data registered one cycle after strobe
// Notes: memory is a ring of FHM_DEPTH entries; overflow drops the oldest
`timescale 1ns/1ns
`include "fhm_regs.svh"
module fhm_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // parameter bus
  input wire logic par_rd,
  input wire logic par_wr,
  input wire logic [15:0] par_addr,
  input wire logic [15:0] par_wdata,
  output logic [15:0] par_rdata,
  output logic par_ack,
  // fault capture
  input wire logic flt_detect,
  input wire logic [15:0] flt_code,
  input wire logic [2:0] flt_severity,
  input wire logic [15:0] flt_extra,
  input wire logic [15:0] flt_speed,
  input wire logic [15:0] flt_current,
  input wire logic [15:0] flt_temp,
  input wire logic [31:0] op_seconds,
  // power-on event
  input wire logic power_on_pulse,
  // status
  output logic [`FHM_CNT_W-1:0] entry_count,
  output logic erase_busy
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    fhm_pkg::fhm_state_t state;
    logic [`FHM_PTR_W-1:0] head;
    logic [`FHM_PTR_W-1:0] rd_ptr;
    logic [`FHM_CNT_W-1:0] count;
    logic [`FHM_CNT_W-1:0] rd_left;
    fhm_pkg::fhm_entry_t hold;
    logic [31:0] power_on;
    logic [15:0] rdata;
    logic ack;
  } fhm_state_all_t;

  fhm_state_all_t cur_ff, nxt_ff;
  fhm_pkg::fhm_entry_t rd_entry;
  fhm_pkg::fhm_entry_t new_entry;
  logic wr_en;
  logic [`FHM_PTR_W-1:0] oldest;
  logic [`FHM_PTR_W-1:0] wr_idx;

  function automatic logic [`FHM_PTR_W-1:0] ptr_inc(input logic [`FHM_PTR_W-1:0] p);
    ptr_inc = p + `FHM_PTR_W'(1);
  endfunction

  function automatic logic [15:0] sat_time(input logic [31:0] s, input logic hi);
    logic [31:0] t;
    t = (s > `FHM_TIME_MAX) ? `FHM_TIME_MAX : s;
    sat_time = hi ? t[31:16] : t[15:0];
  endfunction

  // ---------------------------------------------------------------
  // entry store
  // ---------------------------------------------------------------
  always_comb begin
    new_entry.code = flt_code;
    new_entry.severity = (flt_severity > `FHM_CLASS_MAX) ? `FHM_CLASS_MAX : flt_severity;
    new_entry.stamp = (op_seconds > `FHM_TIME_MAX) ? `FHM_TIME_MAX : op_seconds;
    new_entry.extra = flt_extra;
    new_entry.speed = flt_speed;
    new_entry.current = flt_current;
    new_entry.temp = flt_temp;
  end

  assign wr_en = flt_detect && (cur_ff.state == fhm_pkg::FHM_IDLE);
  assign wr_idx = cur_ff.head;
  assign oldest = cur_ff.head - cur_ff.count[`FHM_PTR_W-1:0];

  fhm_store u_store (
    .core_clk(core_clk),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_entry(new_entry),
    .rd_idx(cur_ff.rd_ptr),
    .rd_entry(rd_entry)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic rd_code;
    logic full;
    rd_code = par_rd && (par_addr == `FHM_OFS_CODE);
    full = (cur_ff.count == `FHM_CNT_W'(`FHM_DEPTH));
    nxt_ff = cur_ff;
    nxt_ff.ack = par_rd || par_wr;
    nxt_ff.rdata = 16'h0000;
    if (power_on_pulse) begin
      nxt_ff.power_on = cur_ff.power_on + 32'h00000001;
    end
    unique case (cur_ff.state)
      fhm_pkg::FHM_IDLE: begin
        if (wr_en) begin
          // append in time order, overwriting oldest when full
          nxt_ff.head = ptr_inc(cur_ff.head);
          if (!full) begin
            nxt_ff.count = cur_ff.count + `FHM_CNT_W'(1);
          end
          // all unread: overwritten entry is lost, else one more unread
          if (cur_ff.rd_left == `FHM_CNT_W'(`FHM_DEPTH)) begin
            nxt_ff.rd_ptr = ptr_inc(cur_ff.rd_ptr);
          end else begin
            nxt_ff.rd_left = cur_ff.rd_left + `FHM_CNT_W'(1);
          end
        end
        if (rd_code) begin
          if (cur_ff.rd_left != `FHM_CNT_W'(0)) begin
            nxt_ff.hold = rd_entry;
            nxt_ff.rd_ptr = ptr_inc(cur_ff.rd_ptr);
            nxt_ff.rd_left = nxt_ff.rd_left - `FHM_CNT_W'(1);
          end else begin
            nxt_ff.hold = '0;
          end
        end
        if (par_wr && (par_addr == `FHM_OFS_REWIND) && (par_wdata == `FHM_CMD_ONE)) begin
          nxt_ff.rd_ptr = wr_en && full ? ptr_inc(oldest) : oldest;
          nxt_ff.rd_left = nxt_ff.count;
        end
        if (par_wr && (par_addr == `FHM_OFS_CLEAR) && (par_wdata == `FHM_CMD_ONE)) begin
          nxt_ff.state = fhm_pkg::FHM_ERASE;
        end
      end
      fhm_pkg::FHM_ERASE: begin
        // erase takes one cycle; busy read back only by a poll in the same cycle as the clear write
        nxt_ff.count = '0;
        nxt_ff.rd_left = '0;
        nxt_ff.rd_ptr = cur_ff.head;
        nxt_ff.hold = '0;
        nxt_ff.state = fhm_pkg::FHM_IDLE;
      end
      default: begin
        nxt_ff.state = fhm_pkg::FHM_IDLE;
      end
    endcase
    if (par_rd) begin
      unique case (par_addr)
        `FHM_OFS_PWR_ON_LO: nxt_ff.rdata = cur_ff.power_on[15:0];
        `FHM_OFS_PWR_ON_HI: nxt_ff.rdata = cur_ff.power_on[31:16];
        `FHM_OFS_CLEAR: nxt_ff.rdata = {15'h0000, nxt_ff.state == fhm_pkg::FHM_ERASE};
        `FHM_OFS_REWIND: nxt_ff.rdata = 16'h0000;
        `FHM_OFS_CODE: nxt_ff.rdata = nxt_ff.hold.code;
        `FHM_OFS_CLASS: nxt_ff.rdata = {13'h0000, cur_ff.hold.severity};
        `FHM_OFS_TIME_LO: nxt_ff.rdata = sat_time(cur_ff.hold.stamp, 1'b0);
        `FHM_OFS_TIME_HI: nxt_ff.rdata = sat_time(cur_ff.hold.stamp, 1'b1);
        `FHM_OFS_QUAL: nxt_ff.rdata = cur_ff.hold.extra;
        `FHM_OFS_SPEED: nxt_ff.rdata = cur_ff.hold.speed;
        `FHM_OFS_CURRENT: nxt_ff.rdata = cur_ff.hold.current;
        `FHM_OFS_TEMP: nxt_ff.rdata = cur_ff.hold.temp;
        default: nxt_ff.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= '{state: fhm_pkg::FHM_IDLE, default: '0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign par_rdata = cur_ff.rdata;
  assign par_ack = cur_ff.ack;
  assign entry_count = cur_ff.count;
  assign erase_busy = cur_ff.state[1];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  latch_on_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (par_rd && par_addr == `FHM_OFS_CODE && cur_ff.state == fhm_pkg::FHM_IDLE && cur_ff.rd_left != 0
     && !(par_wr && par_addr == `FHM_OFS_CLEAR))
    |=> (cur_ff.hold == $past(rd_entry) && par_rdata == $past(rd_entry.code)))
    else $error("entry not latched on code read");
  ptr_advance_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (par_rd && !par_wr && par_addr == `FHM_OFS_CODE && cur_ff.state == fhm_pkg::FHM_IDLE && cur_ff.rd_left != 0
     && !wr_en) |=> cur_ff.rd_ptr == $past(cur_ff.rd_ptr) + 3'h1)
    else $error("read pointer did not advance");
  rewind_oldest_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (par_wr && par_addr == `FHM_OFS_REWIND && par_wdata == 16'h0001 && cur_ff.state == fhm_pkg::FHM_IDLE && !wr_en)
    |=> (cur_ff.rd_ptr == cur_ff.head - cur_ff.count[2:0] && cur_ff.rd_left == cur_ff.count))
    else $error("rewind missed oldest entry");
  clear_empties_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (par_wr && par_addr == `FHM_OFS_CLEAR && par_wdata == 16'h0001 && cur_ff.state == fhm_pkg::FHM_IDLE)
    |=> erase_busy ##1 (entry_count == 0 && !erase_busy))
    else $error("clear did not empty memory");
  clear_reads_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (par_rd && par_addr == `FHM_OFS_CLEAR && cur_ff.state == fhm_pkg::FHM_IDLE && !par_wr)
    |=> par_rdata == 16'h0000)
    else $error("clear register not zero when idle");
  class_range_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cur_ff.hold.severity <= 3'h4)
    else $error("error class out of range");
  power_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
    power_on_pulse |=> cur_ff.power_on == $past(cur_ff.power_on) + 32'h1)
    else $error("power-on count not incremented");
  time_cap_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cur_ff.hold.stamp <= 32'h1fffffff)
    else $error("error time above limit");
  entry_append_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (wr_en && entry_count < 4'h8) |=> entry_count == $past(entry_count) + 4'h1)
    else $error("fault not appended");
  ack_answer_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (par_rd || par_wr) |=> par_ack)
    else $error("bus access not acknowledged");
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !par_rd |=> par_rdata == 16'h0000)
    else $error("read data not cleared after read");
  rewind_refuse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (par_wr && par_addr == `FHM_OFS_REWIND && par_wdata != 16'h0001 && !par_rd && !wr_en)
    |=> cur_ff.rd_ptr == $past(cur_ff.rd_ptr))
    else $error("rewind taken with wrong value");
  power_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !power_on_pulse |=> cur_ff.power_on == $past(cur_ff.power_on))
    else $error("power-on count changed without event");
endmodule

// *** verif/fhm_fault_src.sv ***
// Purpose: fault source model feeding the capture port of the fault history memory
// Assumes: fire is a one-cycle pulse set by the bench; idx selects the snapshot pattern
// Notes: fields show inverted values outside the detect cycle
`timescale 1ns/1ns
module fhm_fault_src (
  // request from bench
  input wire logic fire,
  input wire logic [2:0] idx,
  // capture port
  output logic flt_detect,
  output logic [15:0] flt_code,
  output logic [2:0] flt_severity,
  output logic [15:0] flt_extra,
  output logic [15:0] flt_speed,
  output logic [15:0] flt_current,
  output logic [15:0] flt_temp,
  output logic [31:0] op_seconds
);
  logic [114:0] val;
  assign val = {16'ha000 + 16'(idx), idx, 16'h3c00 + 16'(idx), 16'hff00 + 16'(idx), 16'h0100 * 16'(idx),
                16'hfff0 + 16'(idx), (idx == 3'h7) ? 32'hffffffff : 32'h00000010 + 32'(idx)};
  // stale snapshot must never pass for a fresh one
  assign {flt_code, flt_severity, flt_extra, flt_speed, flt_current, flt_temp, op_seconds} = fire ? val : ~val;
  assign flt_detect = fire;
endmodule

// *** verif/tb_fault_history_memory.sv ***
// Purpose: self-checking bench of the fault history memory
// Assumes: parameter bus answers one cycle after the strobe
// Notes: faults come from the fault source model
`timescale 1ns/1ns
`include "fhm_regs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_fault_history_memory;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic par_rd = 1'b0;
  logic par_wr = 1'b0;
  logic [15:0] par_addr = 16'h0000;
  logic [15:0] par_wdata = 16'h0000;
  logic [15:0] par_rdata;
  logic par_ack;
  logic fire = 1'b0;
  logic [2:0] idx = 3'h0;
  logic power_on_pulse = 1'b0;
  logic flt_detect;
  logic [15:0] flt_code, flt_extra, flt_speed, flt_current, flt_temp;
  logic [2:0] flt_severity;
  logic [31:0] op_seconds;
  logic [`FHM_CNT_W-1:0] entry_count;
  logic erase_busy;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [15:0] q;
  logic [31:0] t;
  logic [2:0] list [3] = '{3'h3, 3'h5, 3'h7};

  always #50 core_clk = ~core_clk;

  fhm_top fhm_top_inst (.core_clk(core_clk), .rstn(rstn), .par_rd(par_rd), .par_wr(par_wr),
    .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack),
    .flt_detect(flt_detect), .flt_code(flt_code), .flt_severity(flt_severity), .flt_extra(flt_extra),
    .flt_speed(flt_speed), .flt_current(flt_current), .flt_temp(flt_temp), .op_seconds(op_seconds),
    .power_on_pulse(power_on_pulse), .entry_count(entry_count), .erase_busy(erase_busy));

  fhm_fault_src fhm_fault_src_inst (.fire(fire), .idx(idx), .flt_detect(flt_detect), .flt_code(flt_code),
    .flt_severity(flt_severity), .flt_extra(flt_extra), .flt_speed(flt_speed), .flt_current(flt_current),
    .flt_temp(flt_temp), .op_seconds(op_seconds));

  // ----------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] r);
    @(posedge core_clk);
    par_rd <= ~w;
    par_wr <= w;
    par_addr <= a;
    par_wdata <= d;
    @(posedge core_clk);
    par_rd <= 1'b0;
    par_wr <= 1'b0;
    #1;
    r = par_rdata;
    `CHK(par_ack, 1'b1)
  endtask

  task automatic inject(input logic [2:0] i);
    @(posedge core_clk);
    fire <= 1'b1;
    idx <= i;
    @(posedge core_clk);
    fire <= 1'b0;
  endtask

  task results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 3; k++) inject(list[k]);
    #1;
    `CHK(entry_count, 4'h3)
    foreach (list[k]) begin
      t = (list[k] == 3'h7) ? 32'h1fffffff : 32'h00000010 + 32'(list[k]);
      acc(1'b0, `FHM_OFS_CODE, 16'h0000, q);
      `CHK(q, 16'ha000 + 16'(list[k]))
      acc(1'b0, `FHM_OFS_CLASS, 16'h0000, q);
      `CHK(q, 16'((list[k] > 3'h4) ? 3'h4 : list[k]))
      acc(1'b0, `FHM_OFS_QUAL, 16'h0000, q);
      `CHK(q, 16'h3c00 + 16'(list[k]))
      acc(1'b0, `FHM_OFS_SPEED, 16'h0000, q);
      `CHK(q, 16'hff00 + 16'(list[k]))
      acc(1'b0, `FHM_OFS_CURRENT, 16'h0000, q);
      `CHK(q, 16'h0100 * 16'(list[k]))
      acc(1'b0, `FHM_OFS_TEMP, 16'h0000, q);
      `CHK(q, 16'hfff0 + 16'(list[k]))
      acc(1'b0, `FHM_OFS_TIME_LO, 16'h0000, q);
      `CHK(q, t[15:0])
      acc(1'b0, `FHM_OFS_TIME_HI, 16'h0000, q);
      `CHK(q, t[31:16])
    end
    acc(1'b0, `FHM_OFS_CODE, 16'h0000, q);
    `CHK(q, 16'h0000)
    $display("test readout done");
    acc(1'b1, `FHM_OFS_REWIND, `FHM_CMD_ONE, q);
    acc(1'b0, `FHM_OFS_CODE, 16'h0000, q);
    `CHK(q, 16'ha003)
    acc(1'b1, `FHM_OFS_REWIND, 16'h0002, q);
    acc(1'b0, `FHM_OFS_CODE, 16'h0000, q);
    `CHK(q, 16'ha005)
    $display("test rewind done");
    repeat (2) begin
      @(posedge core_clk);
      power_on_pulse <= 1'b1;
      @(posedge core_clk);
      power_on_pulse <= 1'b0;
    end
    acc(1'b1, `FHM_OFS_PWR_ON_LO, 16'hffff, q);
    acc(1'b0, `FHM_OFS_PWR_ON_LO, 16'h0000, q);
    `CHK(q, 16'h0002)
    acc(1'b0, `FHM_OFS_PWR_ON_HI, 16'h0000, q);
    `CHK(q, 16'h0000)
    acc(1'b0, 16'h3c30, 16'h0000, q);
    `CHK(q, 16'h0000)
    $display("test power-on counter done");
    acc(1'b1, `FHM_OFS_CLEAR, `FHM_CMD_ONE, q);
    `CHK(erase_busy, 1'b1)
    // poll until erase reports done
    for (int n = 0; n < 20; n++) begin
      acc(1'b0, `FHM_OFS_CLEAR, 16'h0000, q);
      if (q === 16'h0000) break;
    end
    `CHK(q, 16'h0000)
    `CHK(entry_count, 4'h0)
    `CHK(erase_busy, 1'b0)
    acc(1'b0, `FHM_OFS_CODE, 16'h0000, q);
    `CHK(q, 16'h0000)
    $display("test clear done");
    for (int k = 0; k < 9; k++) inject(3'(k));
    #1;
    `CHK(entry_count, 4'h8)
    acc(1'b0, `FHM_OFS_CODE, 16'h0000, q);
    `CHK(q, 16'ha001)
    $display("test overflow done");
    results();
  end
endmodule
